// ==== hw/poc_top.sv ====
/*
 * control/status logic of a pluggable optic: shutdown pin, latched fault,
 * loss of signal, and an eeprom-style two-wire slave over two spaces.
 * assumes scl/sda/shutdown pins are asynchronous and synchronised here;
 * the host pulls sda up and keeps its own shutdown spacing.
 */
// Overview of operation
// RULE1 - answer two-wire transfers like small serial eeprom
// RULE2 - identification space, 256 bytes, at A0
// RULE3 - diagnostic space, 256 bytes, at A2
// RULE4 - B0 reserved, never acknowledged
// RULE5 - shutdown pin high turns transmitter off
// RULE6 - floating shutdown pin counts as asserted
// RULE7 - host spaces shutdown assertions 10 ms apart
// RULE8 - byte 110: bit6 soft shutdown, bit7 pin
// RULE9 - transmitter off is soft OR pin
// RULE10 - laser fault raises fault output, laser off
// RULE11 - fault latches until shutdown toggles
// RULE12 - shutdown cycle clears fault, allows restart
// RULE13 - latched fault shown in byte 110 bit2
// RULE14 - unsafe optical level disables transmitter
// RULE15 - shutdown and loss states mirrored readable
// RULE16 - loss output high when input unusable, bit1
// RULE17 - byte 110 reads return live states
`timescale 1ns/1ps
module poc_top (
    input  wire logic clock_in,
    input  wire logic nrst_in,
    input  wire logic scl_in,                // serial clock pin
    input  wire logic sda_in,                // serial data pin level
    output logic      sda_out,               // always low when driven
    output logic      sda_oe_out,            // high pulls sda low
    input  wire logic tx_shutdown_in,        // pin, pulled up outside
    input  wire logic laser_fault_in,        // catastrophic fault detect
    input  wire logic unsafe_power_in,       // eye safety monitor
    input  wire logic signal_unusable_in,    // receive detector
    output logic      laser_enable_out,      // high lets laser emit
    output logic      tx_fault_out,          // latched fault
    output logic      receive_signal_lost_out
);
    typedef struct packed {
        logic [1:0]          scl_s;   // scl sync
        logic [1:0]          sda_s;   // sda sync
        logic [1:0]          dis_s;   // shutdown sync
        logic [1:0]          flt_s;
        logic [1:0]          uns_s;
        logic [1:0]          los_s;
        logic                scl_d;   // last synced scl
        logic                sda_d;   // last synced sda
        logic                dis_d;   // last synced shutdown
        poc_pkg::poc_state_t st;
        logic [3:0]          bitn;    // bit counter
        logic [7:0]          shreg;   // shift register
        logic                space;   // 1 = diagnostic
        logic [7:0]          ofs;     // byte pointer
        logic                soft_off;
        logic                fault;
        logic                ack;     // driving ack low
        logic                drive;   // sda driven low
        logic [7:0]          hold;    // hold-time counter
        logic                pend;    // sda change waiting on hold
        logic                pend_v;
        logic                las;
        logic                los;
    } poc_s_t;

    poc_s_t     s_reg;                // all state
    poc_s_t     s_next;               // next state
    logic       mem_we;               // memory write strobe
    logic [7:0] mem_rd;               // memory read data
    logic [7:0] live_byte;            // control/status byte

    // live control/status byte
    function automatic logic [7:0] ctrl_byte(input poc_s_t s);
        logic [7:0] b;
        b = poc_pkg::CTRL_RESET;
        b[poc_pkg::BIT_PIN_OFF]  = s.dis_s[1];   // [RULE8] [RULE15]
        b[poc_pkg::BIT_SOFT_OFF] = s.soft_off;   // [RULE8]
        b[poc_pkg::BIT_FAULT]    = s.fault;      // [RULE13]
        b[poc_pkg::BIT_LOS]      = s.los_s[1];   // [RULE16] [RULE15]
        return b;
    endfunction

    assign live_byte = ctrl_byte(s_reg);
    assign mem_we = (s_reg.st == poc_pkg::ST_WDATA) && (s_reg.bitn == poc_pkg::BIT_LAST)
                    && s_reg.scl_s[1] && !s_reg.scl_d;

    poc_mem u_mem (
        .clock_in  (clock_in),
        .we_in     (mem_we),
        .addr_in   ({s_reg.space, s_reg.ofs}),
        .wdata_in  ({s_reg.shreg[6:0], s_reg.sda_s[1]}),
        .rdata_out (mem_rd)
    );

    // next-state logic: pins, fault latch, serial slave
    always_comb begin
        logic rise;
        logic fall;
        logic start;
        logic stop;
        logic [7:0] rbyte;
        s_next = s_reg;
        rise  = s_reg.scl_s[1] && !s_reg.scl_d;
        fall  = !s_reg.scl_s[1] && s_reg.scl_d;
        start = s_reg.scl_s[1] && s_reg.sda_d && !s_reg.sda_s[1];
        stop  = s_reg.scl_s[1] && !s_reg.sda_d && s_reg.sda_s[1];
        rbyte = (s_reg.space && s_reg.ofs == poc_pkg::CTRL_STAT_OFS) ? live_byte : mem_rd;
        s_next.scl_s = {s_reg.scl_s[0], scl_in};
        s_next.sda_s = {s_reg.sda_s[0], sda_in};
        s_next.dis_s = {s_reg.dis_s[0], tx_shutdown_in};  // [RULE6] pull-up outside
        s_next.flt_s = {s_reg.flt_s[0], laser_fault_in};
        s_next.uns_s = {s_reg.uns_s[0], unsafe_power_in};
        s_next.los_s = {s_reg.los_s[0], signal_unusable_in};
        s_next.scl_d = s_reg.scl_s[1];
        s_next.sda_d = s_reg.sda_s[1];
        s_next.dis_d = s_reg.dis_s[1];
        s_next.los   = s_reg.los_s[1];                    // [RULE16]
        // fault latch; falling edge of shutdown clears, new fault wins
        if (s_reg.flt_s[1]) begin
            s_next.fault = 1'b1;                          // [RULE10] [RULE11]
        end else if (s_reg.dis_d && !s_reg.dis_s[1]) begin
            s_next.fault = 1'b0;                          // [RULE11] [RULE12]
        end
        s_next.las = !(s_reg.dis_s[1] || s_reg.soft_off)  // [RULE5] [RULE9]
                     && !s_next.fault && !s_reg.flt_s[1]  // [RULE10]
                     && !s_reg.uns_s[1];                  // [RULE14]
        // delayed sda change after scl falls
        if (s_reg.hold != 8'h00) begin
            s_next.hold = s_reg.hold - 8'h01;
        end else if (s_reg.pend) begin
            s_next.drive = s_reg.pend_v;
            s_next.pend  = 1'b0;
        end
        if (start) begin
            s_next.st = poc_pkg::ST_ADDR;                 // [RULE1]
            s_next.bitn = 4'h0;
            s_next.drive = 1'b0;
            s_next.pend = 1'b0;
        end else if (stop) begin
            s_next.st = poc_pkg::ST_IDLE;
            s_next.drive = 1'b0;
            s_next.pend = 1'b0;
        end else if (rise && s_reg.st != poc_pkg::ST_IDLE) begin
            if (s_reg.bitn == poc_pkg::BIT_ACK) begin
                s_next.bitn = 4'h0;
                if (s_reg.st == poc_pkg::ST_RACK && s_reg.sda_s[1]) begin
                    s_next.st = poc_pkg::ST_IDLE;         // master nack ends read
                end else if (s_reg.st == poc_pkg::ST_RACK) begin
                    s_next.st = poc_pkg::ST_READ;
                end else if (!s_reg.ack) begin
                    s_next.st = poc_pkg::ST_IDLE;
                end
            end else begin
                s_next.shreg = {s_reg.shreg[6:0], s_reg.sda_s[1]};
                s_next.bitn  = s_reg.bitn + 4'h1;
            end
        end else if (fall && s_reg.st != poc_pkg::ST_IDLE) begin
            s_next.hold = 8'(poc_pkg::HOLD_CYC);
            s_next.pend = 1'b1;
            s_next.pend_v = 1'b0;
            if (s_reg.bitn == poc_pkg::BIT_ACK) begin
                // address/data byte just completed: decide ack
                s_next.ack = 1'b0;
                case (s_reg.st)
                    poc_pkg::ST_ADDR: begin
                        if (s_reg.shreg[7:1] == poc_pkg::DEV_ID_ADDR ||
                            s_reg.shreg[7:1] == poc_pkg::DEV_DIAG_ADDR) begin
                            s_next.ack = 1'b1;            // [RULE2] [RULE3] [RULE4]
                            s_next.space = s_reg.shreg[1];
                            s_next.st = s_reg.shreg[0] ? poc_pkg::ST_READ
                                                       : poc_pkg::ST_WOFS;
                        end
                    end
                    poc_pkg::ST_WOFS: begin
                        s_next.ack = 1'b1;
                        s_next.ofs = s_reg.shreg;
                        s_next.st  = poc_pkg::ST_WDATA;
                    end
                    poc_pkg::ST_WDATA: begin
                        s_next.ack = 1'b1;
                        if (s_reg.space && s_reg.ofs == poc_pkg::CTRL_STAT_OFS) begin
                            s_next.soft_off = s_reg.shreg[poc_pkg::BIT_SOFT_OFF]; // [RULE8]
                        end
                        s_next.ofs = s_reg.ofs + 8'h01;
                    end
                    poc_pkg::ST_READ: begin
                        s_next.ofs = s_reg.ofs + 8'h01;
                        s_next.st  = poc_pkg::ST_RACK;
                    end
                    default: begin
                        s_next.ack = 1'b0;
                    end
                endcase
                s_next.pend_v = s_next.ack;
                if (s_reg.st == poc_pkg::ST_ADDR && s_reg.shreg[0] && s_next.ack) begin
                    s_next.bitn = poc_pkg::BIT_ACK;
                end
            end else if (s_reg.st == poc_pkg::ST_READ) begin
                s_next.pend_v = !rbyte[3'(poc_pkg::BIT_LAST - s_reg.bitn)]; // [RULE17]
            end
        end
    end

    // state register
    always_ff @(posedge clock_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.dis_s <= 2'b11;   // off until pin seen low [RULE6]
            s_reg.dis_d <= 1'b1;
            s_reg.scl_s <= 2'b11;
            s_reg.sda_s <= 2'b11;
            s_reg.scl_d <= 1'b1;
            s_reg.sda_d <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_out = s_reg.drive;
    assign laser_enable_out = s_reg.las;
    assign tx_fault_out = s_reg.fault;
    assign receive_signal_lost_out = s_reg.los;

    a_fault_latch: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE11]
        $rose(s_reg.flt_s[1]) |=> tx_fault_out [*2]) else $error("fault not latched");
    a_laser_off_pin: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE5]
        s_reg.dis_s[1] |=> !laser_enable_out) else $error("laser on with pin high");
    a_laser_off_soft: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE9]
        s_reg.soft_off |=> !laser_enable_out) else $error("laser on with soft off");
    a_laser_off_fault: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE10]
        tx_fault_out |-> !laser_enable_out) else $error("laser on during fault");
    a_unsafe_off: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE14]
        s_reg.uns_s[1] |=> !laser_enable_out) else $error("laser on while unsafe");
    a_fault_clear: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE12]
        $fell(s_reg.dis_s[1]) && !s_reg.flt_s[1] |=> !tx_fault_out) else $error("fault stuck");
    a_los_follow: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE16]
        s_reg.los_s[1] |=> receive_signal_lost_out) else $error("los not shown");
    // the fault bit served on the wire during a status byte read
    a_status_bits: assert property (@(posedge clock_in) disable iff (!nrst_in) // [RULE13]
        s_reg.st == poc_pkg::ST_READ && s_reg.space && s_reg.ofs == poc_pkg::CTRL_STAT_OFS
        && s_reg.bitn == poc_pkg::BIT_LAST - 4'(poc_pkg::BIT_FAULT)
        && !s_reg.scl_s[1] && s_reg.scl_d
        |=> s_reg.pend_v == !$past(tx_fault_out)) else $error("fault bit not served");
endmodule

// ==== shared/poc_pkg.sv ====
/*
 * constants for the pluggable optic control and status block:
 * serial device addresses, memory size, status byte layout, timing.
 * assumes a 200 MHz core clock.
 */
package poc_pkg;
    localparam logic [6:0] DEV_ID_ADDR   = 7'h50;  // 8-bit form A0
    localparam logic [6:0] DEV_DIAG_ADDR = 7'h51;  // 8-bit form A2
    localparam logic [6:0] DEV_TEST_ADDR = 7'h58;  // 8-bit form B0, never answered
    localparam int         MEM_AW        = 9;      // two 256-byte spaces
    localparam logic [7:0] CTRL_STAT_OFS = 8'h6E;  // control/status byte
    localparam int         BIT_PIN_OFF   = 7;
    localparam int         BIT_SOFT_OFF  = 6;
    localparam int         BIT_FAULT     = 2;
    localparam int         BIT_LOS       = 1;
    localparam logic [7:0] CTRL_RESET    = 8'h00;
    localparam int         CLK_MHZ       = 200;
    localparam int         HOLD_NS       = 300;    // sda hold after scl falls
    localparam int         HOLD_CYC      = (HOLD_NS * CLK_MHZ + 999) / 1000;
    localparam logic [3:0] BIT_LAST      = 4'h7;
    localparam logic [3:0] BIT_ACK       = 4'h8;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ADDR  = 3'b001,
        ST_WOFS  = 3'b010,
        ST_WDATA = 3'b011,
        ST_READ  = 3'b100,
        ST_RACK  = 3'b101
    } poc_state_t;
endpackage

// ==== hw/poc_mem.sv ====
/*
 * two 256-byte spaces as one 512-byte memory, registered read data.
 * assumes contents are loaded by serial writes; no preload.
 */
`timescale 1ns/1ps
module poc_mem (
    input  wire logic                       clock_in,
    input  wire logic                       we_in,
    input  wire logic [poc_pkg::MEM_AW-1:0] addr_in,
    input  wire logic [7:0]                 wdata_in,
    output logic      [7:0]                 rdata_out
);
    logic [7:0] mem [0:(1<<poc_pkg::MEM_AW)-1];  // byte array

    // write port and registered read port
    always_ff @(posedge clock_in) begin
        if (we_in) begin
            mem[addr_in] <= wdata_in;
        end
        rdata_out <= mem[addr_in];
    end
endmodule

// ==== dv/poc_host_model.sv ====
/*
 * host side of the optic: two-wire master and shutdown pin driver.
 * assumes the bench resolves sda from both pull-downs with a pull-up.
 */
`timescale 1ns/1ps
module poc_host_model #(
    parameter int GAP_CYC = 2_000_000     // shutdown assertion spacing, cycles
) (
    input  wire logic clock_in,
    input  wire logic sda_in,             // resolved sda level
    output logic      scl_out,            // serial clock, idle high
    output logic      sda_low_out,        // high pulls sda low
    output logic      shdn_drive_out,     // high drives the shutdown pin
    output logic      shdn_level_out      // pin level while driven
);
    int cyc = 0;                          // free cycle count
    int last_assert = 0;                  // cycle of last shutdown assertion
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
        shdn_drive_out = 1'b0;
        shdn_level_out = 1'b0;
    end
    // cycle count for spacing
    always @(posedge clock_in) cyc <= cyc + 1;
    // wait n falling edges
    task automatic hc(input int n);
        repeat (n) @(negedge clock_in);
    endtask
    // shutdown pin; an assertion waits out the spacing
    task automatic shdn(input logic drive, input logic lvl);
        if (!drive || lvl) begin
            while (cyc - last_assert < GAP_CYC) hc(1);
            last_assert = cyc;
        end
        shdn_drive_out = drive;
        shdn_level_out = lvl;
    endtask
    // one bit: set while scl low, sample mid-high
    task automatic bit_io(input logic b, output logic r);
        hc(80);
        sda_low_out = !b;
        hc(20);
        scl_out = 1'b1;
        hc(50);
        r = sda_in;
        hc(50);
        scl_out = 1'b0;
    endtask
    // start or repeated start
    task automatic start();
        hc(80);
        sda_low_out = 1'b0;
        hc(20);
        scl_out = 1'b1;
        hc(50);
        sda_low_out = 1'b1;
        hc(50);
        scl_out = 1'b0;
    endtask
    // stop, then bus idle
    task automatic stop();
        hc(80);
        sda_low_out = 1'b1;
        hc(20);
        scl_out = 1'b1;
        hc(50);
        sda_low_out = 1'b0;
        hc(100);
    endtask
    // eight bits msb first, then the ninth
    task automatic byte_io(input logic [7:0] tx, input logic ab,
                           output logic [7:0] rx, output logic a);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(ab, a);
    endtask
endmodule

// ==== dv/test_pluggable_optic_control_status.sv ====
/*
 * self-checking bench for the optic control and status block.
 * assumes the host model drives serial and shutdown pins.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_pluggable_optic_control_status;
    logic       clock_in;                 // 200 MHz
    logic       nrst_in;                  // active low reset
    logic       fault;                    // laser fault detect
    logic       unsafe;                   // eye safety monitor
    logic       los;                      // receive detector
    logic       scl, host_low, drv, lvl;  // host model pins
    logic       sda_oe, sda_o, laser, txf, los_out;
    logic       sda_line, shdn_pin;       // resolved wires
    logic [7:0] d;                        // read data
    logic       a;                        // ack level
    int         num_errors = 0;
    int         check_count = 0;
    int         cyc = 0;
    localparam logic [6:0] ID = poc_pkg::DEV_ID_ADDR;
    localparam logic [6:0] DG = poc_pkg::DEV_DIAG_ADDR;
    localparam logic [7:0] CS = poc_pkg::CTRL_STAT_OFS;
    // pull-up on sda and on the shutdown pin
    assign sda_line = (sda_oe ? sda_o : 1'b1) & !host_low;
    assign shdn_pin = drv ? lvl : 1'b1;
    always #2.5 clock_in = ~clock_in;
    poc_host_model #(.GAP_CYC(2000)) i_host (.clock_in(clock_in), .sda_in(sda_line),
        .scl_out(scl), .sda_low_out(host_low), .shdn_drive_out(drv), .shdn_level_out(lvl));
    poc_top i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_o), .sda_oe_out(sda_oe), .tx_shutdown_in(shdn_pin),
        .laser_fault_in(fault), .unsafe_power_in(unsafe), .signal_unusable_in(los),
        .laser_enable_out(laser), .tx_fault_out(txf), .receive_signal_lost_out(los_out));
    // verdict and end of run
    task automatic results();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // byte that the slave must acknowledge
    task automatic send(input logic [7:0] b);
        logic [7:0] r;
        logic       k;
        i_host.byte_io(b, 1'b1, r, k);
        `CHK("ack", 1'b0, k)
    endtask
    task automatic wr(input logic [6:0] dev, input logic [7:0] ofs, input logic [7:0] v);
        i_host.start();
        send({dev, 1'b0});
        send(ofs);
        send(v);
        i_host.stop();
    endtask
    // pointer set, repeated start, one byte then nack
    task automatic rd(input logic [6:0] dev, input logic [7:0] ofs, output logic [7:0] v);
        logic k;
        i_host.start();
        send({dev, 1'b0});
        send(ofs);
        i_host.start();
        send({dev, 1'b1});
        i_host.byte_io(8'hFF, 1'b1, v, k);
        i_host.stop();
    endtask
    // hang guard
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 90000) begin
            num_errors++;
            results();
        end
    end
    // main sequence
    initial begin
        clock_in = 1'b0;
        nrst_in = 1'b0;
        fault = 1'b0;
        unsafe = 1'b0;
        los = 1'b1;
        repeat (20) @(negedge clock_in);
        nrst_in = 1'b1;
        i_host.hc(10);
        `CHK("laser_float", 1'b0, laser)
        wr(DG, CS, 8'h40);
        rd(DG, CS, d);
        `CHK("ctrl_pin_soft", 8'hC2, d)
        `CHK("los_out", 1'b1, los_out)
        i_host.shdn(1'b1, 1'b0);
        i_host.hc(10);
        `CHK("laser_soft", 1'b0, laser)
        los = 1'b0;
        wr(DG, CS, 8'h00);
        i_host.hc(10);
        `CHK("laser_on", 1'b1, laser)
        `CHK("los_clear", 1'b0, los_out)
        wr(ID, 8'h10, 8'hA5);
        wr(DG, 8'h10, 8'h3C);
        rd(ID, 8'h10, d);
        `CHK("id_byte", 8'hA5, d)
        rd(DG, 8'h10, d);
        `CHK("diag_byte", 8'h3C, d)
        // two-byte write with pointer increment
        i_host.start();
        send({ID, 1'b0});
        send(8'h11);
        send(8'h5A);
        send(8'hC3);
        i_host.stop();
        // sequential read, master ack between bytes, nack on the last
        i_host.start();
        send({ID, 1'b0});
        send(8'h10);
        i_host.start();
        send({ID, 1'b1});
        i_host.byte_io(8'hFF, 1'b0, d, a);
        `CHK("seq_byte0", 8'hA5, d)
        i_host.byte_io(8'hFF, 1'b0, d, a);
        `CHK("seq_byte1", 8'h5A, d)
        i_host.byte_io(8'hFF, 1'b1, d, a);
        `CHK("seq_byte2", 8'hC3, d)
        i_host.stop();
        i_host.start();
        i_host.byte_io({poc_pkg::DEV_TEST_ADDR, 1'b0}, 1'b1, d, a);
        i_host.stop();
        `CHK("test_nack", 1'b1, a)
        fault = 1'b1;
        i_host.hc(10);
        fault = 1'b0;
        i_host.hc(10);
        `CHK("fault_set", 1'b1, txf)
        `CHK("laser_fault", 1'b0, laser)
        rd(DG, CS, d);
        `CHK("ctrl_fault", 8'h04, d)
        `CHK("fault_held", 1'b1, txf)
        i_host.shdn(1'b1, 1'b1);
        i_host.hc(10);
        i_host.shdn(1'b1, 1'b0);
        i_host.hc(10);
        `CHK("fault_clear", 1'b0, txf)
        `CHK("laser_restart", 1'b1, laser)
        unsafe = 1'b1;
        i_host.hc(10);
        `CHK("laser_unsafe", 1'b0, laser)
        unsafe = 1'b0;
        i_host.hc(10);
        `CHK("laser_safe", 1'b1, laser)
        results();
    end
endmodule
